//--- rtl/ccm_pkg.sv
// Shared constants and carriers for the control memory access block
package ccm_pkg;
	// Slot addressing
	localparam int SLOT_BITS = 7;
	localparam int SLOTS = 128;
	localparam int DIR_UP_BIT = 7;
	// Register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	localparam logic [7:0] OFS_SUBSEL = 8'h10;
	localparam logic [7:0] OFS_OUTMODE = 8'h14;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_CODE = 4'h0;
	// Field positions
	localparam int CMD_RD_BIT = 7;
	localparam int BUSY_BIT = 0;
	localparam int STYLE_BIT = 0;
	// Memory operation codes
	localparam logic [2:0] MOC_BOTH = 3'h7;
	localparam logic [3:0] MOC_DATA = 4'h9;
	// Channel function codes
	localparam logic [3:0] CODE_OFF = 4'h0;
	localparam logic [3:0] CODE_64K = 4'h1;
	localparam logic [3:0] CODE_32L = 4'h2;
	localparam logic [3:0] CODE_32H = 4'h3;
	// Output stream
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	localparam int BUF_DEPTH = 2;
	localparam logic [1:0] BUF_FULL = 2'h2;

	// APB request and answer
	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} ccm_apb_req_type;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ccm_apb_rsp_type;
	// Frame timing from the serial interface sequencer
	typedef struct packed {
		logic slotStart;
		logic [SLOT_BITS-1:0] slotNum;
		logic bitTick;
	} ccm_timing_type;
	// Whole state of the block
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] data;
		logic [7:0] addr;
		logic [7:0] subSel;
		logic [7:0] outMode;
		logic busy;
		logic [SLOTS-1:0][3:0] codeUp;
		logic [SLOTS-1:0][3:0] codeDn;
		logic [SLOTS-1:0][7:0] dataUp;
		logic [SLOTS-1:0][7:0] dataDn;
		logic [BUF_DEPTH-1:0][7:0] fifo;
		logic wPtr;
		logic rPtr;
		logic [1:0] cnt;
		logic [7:0] shift;
		logic [2:0] bitPos;
		logic [3:0] curCode;
		logic [7:0] curPtr;
		logic pinOut;
		logic pinOe;
	} ccm_state_type;
endpackage

//--- rtl/ccm_control_memory.sv
`timescale 1ns/1ns
module ccm_control_memory
	import ccm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register bus
	input wire ccm_apb_req_type apbReq,
	output ccm_apb_rsp_type apbRsp,
	// Slot timing
	input wire ccm_timing_type timing,
	// Downstream byte stream
	input wire logic [7:0] inByte,
	input wire logic inValid,
	output logic inReady,
	// Serial output pin
	output logic cfiOut,
	output logic cfiOe,
	// Current slot switching pointer
	output logic [7:0] slotPtr,
	output logic slotPtrValid,
	output logic slotOtherFunc
);
	// Register state and its next value
	ccm_state_type st_reg;
	ccm_state_type st_next;

	// Bus decode helpers
	logic apbWrite;
	logic apbAccess;
	logic cmdTaken;
	logic [SLOT_BITS-1:0] slotIdx;
	logic [3:0] addrCode;
	logic [7:0] addrData;
	logic isRead;
	logic isBoth;
	logic isDataOnly;
	logic pushOk;
	logic bitVal;
	logic bitAct;
	logic [3:0] nextCode; // Code of the slot about to start
	logic [7:0] nextPtr; // Pointer of the slot about to start

	// Offset is one of ours
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFS_CMD) || (a == OFS_DATA) || (a == OFS_ADDR) ||
			(a == OFS_STAT) || (a == OFS_SUBSEL) || (a == OFS_OUTMODE);
	endfunction

	// Bit lies inside the slot's active window
	function automatic logic slotActive(input logic [3:0] code, input logic [1:0] sub,
		input logic [2:0] pos);
		slotActive = 1'b0;
		case (code)
			CODE_OFF:
				slotActive = 1'b0;
			CODE_64K:
				slotActive = 1'b1;
			CODE_32L, CODE_32H:
				slotActive = (pos[2] == sub[1]);
			4'h4, 4'h5, 4'h6, 4'h7:
				slotActive = (pos[2:1] == sub);
			default:
				slotActive = 1'b1;
		endcase
	endfunction

	// Switched channel code, pointer meaningful
	function automatic logic isSwitched(input logic [3:0] code);
		isSwitched = (code != CODE_OFF) && !code[3];
	endfunction

	// Bus strobes and addressed slot lookup
	assign apbAccess = apbReq.psel && apbReq.penable;
	assign apbWrite = apbAccess && apbReq.pwrite;
	// Commands while busy are dropped; the host must poll first
	assign cmdTaken = apbWrite && (apbReq.paddr == OFS_CMD) && !st_reg.busy;
	// Addressed slot; bit 7 of the address picks the block
	assign slotIdx = st_reg.addr[SLOT_BITS-1:0];
	assign addrCode = st_reg.addr[DIR_UP_BIT] ? st_reg.codeUp[slotIdx] : st_reg.codeDn[slotIdx];
	assign addrData = st_reg.addr[DIR_UP_BIT] ? st_reg.dataUp[slotIdx] : st_reg.dataDn[slotIdx];
	assign isRead = st_reg.cmd[CMD_RD_BIT];
	assign isBoth = (st_reg.cmd[6:4] == MOC_BOTH);
	assign isDataOnly = (st_reg.cmd[6:3] == MOC_DATA);
	// Stream handshake and the bit now on the pin
	assign pushOk = inValid && inReady;
	assign bitVal = st_reg.shift[st_reg.bitPos];
	assign bitAct = slotActive(st_reg.curCode, st_reg.subSel[1:0], st_reg.bitPos);
	// Only the downstream block feeds the pin; upstream is storage here
	assign nextCode = st_reg.codeDn[timing.slotNum];
	assign nextPtr = st_reg.dataDn[timing.slotNum];

	// Handshake and answers
	assign inReady = (st_reg.cnt != BUF_FULL);
	assign cfiOut = st_reg.pinOut;
	assign cfiOe = st_reg.pinOe;
	assign slotPtr = st_reg.curPtr;
	assign slotPtrValid = isSwitched(st_reg.curCode);
	assign slotOtherFunc = st_reg.curCode[3];

	// Bus answer; every field is set here so the struct has one driver
	always_comb
	begin
		// No wait states: the access phase always completes at once
		apbRsp.pready = 1'b1;
		// Unmapped offsets answer with an error and read as zero
		apbRsp.pslverr = apbAccess && !mapped(apbReq.paddr);
		// Register bytes, zero-extended
		apbRsp.prdata = 32'h0;
		case (apbReq.paddr)
			OFS_CMD:
				apbRsp.prdata = {24'h0, st_reg.cmd};
			OFS_DATA:
				apbRsp.prdata = {24'h0, st_reg.data};
			OFS_ADDR:
				apbRsp.prdata = {24'h0, st_reg.addr};
			OFS_STAT:
				apbRsp.prdata = {31'h0, st_reg.busy};
			OFS_SUBSEL:
				apbRsp.prdata = {24'h0, st_reg.subSel};
			OFS_OUTMODE:
				apbRsp.prdata = {24'h0, st_reg.outMode};
			default:
				apbRsp.prdata = 32'h0;
		endcase
	end

	// Next state of the whole block
	always_comb
	begin
		st_next = st_reg;
		// Plain register writes
		if (apbWrite)
		begin
			case (apbReq.paddr)
				OFS_DATA:
					st_next.data = apbReq.pwdata[7:0];
				OFS_ADDR:
					st_next.addr = apbReq.pwdata[7:0];
				OFS_SUBSEL:
					st_next.subSel = apbReq.pwdata[7:0];
				OFS_OUTMODE:
					st_next.outMode = apbReq.pwdata[7:0];
				default:
					st_next.busy = st_reg.busy;
			endcase
		end
		// Command starts one access cycle
		if (cmdTaken)
		begin
			st_next.cmd = apbReq.pwdata[7:0];
			st_next.busy = 1'b1;
		end
		// The access itself; other opcodes belong to other memories
		if (st_reg.busy)
		begin
			// One cycle of access, then the result is ready
			st_next.busy = 1'b0;
			// Code read: upper nibble reads zero for a stable value
			if (isBoth && isRead)
				st_next.data = {4'h0, addrCode};
			// Code and data written in the same cycle
			else if (isBoth)
			begin
				if (st_reg.addr[DIR_UP_BIT])
				begin
					st_next.codeUp[slotIdx] = st_reg.cmd[3:0];
					st_next.dataUp[slotIdx] = st_reg.data;
				end
				else
				begin
					st_next.codeDn[slotIdx] = st_reg.cmd[3:0];
					st_next.dataDn[slotIdx] = st_reg.data;
				end
			end
			// Data field read, code left alone
			else if (isDataOnly && isRead)
				st_next.data = addrData;
			// Data field write, code left alone
			else if (isDataOnly)
			begin
				if (st_reg.addr[DIR_UP_BIT])
					st_next.dataUp[slotIdx] = st_reg.data;
				else
					st_next.dataDn[slotIdx] = st_reg.data;
			end
		end
		// Buffer fill side
		if (pushOk)
		begin
			st_next.fifo[st_reg.wPtr] = inByte;
			st_next.wPtr = !st_reg.wPtr;
		end
		// Bit stepping, MSB first
		if (timing.bitTick)
			st_next.bitPos = st_reg.bitPos - 3'h1;
		// Slot start drains one byte; underrun sends idle ones
		if (timing.slotStart)
		begin
			st_next.bitPos = 3'h7;
			st_next.curCode = nextCode;
			st_next.curPtr = nextPtr;
			if (st_reg.cnt != 2'h0)
			begin
				st_next.shift = st_reg.fifo[st_reg.rPtr];
				st_next.rPtr = !st_reg.rPtr;
			end
			else
				st_next.shift = IDLE_BYTE;
		end
		// Occupancy follows push and pop; both in one cycle keep it
		st_next.cnt = st_reg.cnt + {1'b0, pushOk} - {1'b0, timing.slotStart && (st_reg.cnt != 2'h0)};
		// Driver state from style bit
		if (st_reg.outMode[STYLE_BIT])
		begin
			st_next.pinOe = bitAct && !bitVal;
			st_next.pinOut = 1'b0;
		end
		else
		begin
			st_next.pinOe = bitAct;
			st_next.pinOut = bitVal;
		end
	end

	// State register; memory clears so every code starts unassigned
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_reg <= '0;
			st_reg.cmd <= RST_BYTE;
			st_reg.curCode <= RST_CODE;
		end
		else
			st_reg <= st_next;
	end

	// Checks, all on the one clock; none is judged during reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// Command handshake: busy rises after a command, falls one cycle later

	a_busy_after_cmd: assert property (cmdTaken |=> st_reg.busy)
		else $error("busy not set by command");
	a_busy_one_cycle: assert property ($rose(st_reg.busy) |=> !st_reg.busy)
		else $error("busy did not clear after access");

	// Memory access results, two cycles after the command
	a_both_written: assert property ((st_reg.busy && isBoth && !isRead) |=>
		(addrCode == $past(st_reg.cmd[3:0])) && (addrData == $past(st_reg.data)))
		else $error("code and data not stored together");
	a_code_readback: assert property ((st_reg.busy && isBoth && isRead) |=>
		(st_reg.data[3:0] == $past(addrCode)))
		else $error("code not returned in low nibble");
	a_data_only_wr: assert property ((st_reg.busy && isDataOnly && !isRead) |=>
		(addrCode == $past(addrCode)) && (addrData == $past(st_reg.data)))
		else $error("data-only write disturbed code");
	a_data_readback: assert property ((st_reg.busy && isDataOnly && isRead) |=>
		(st_reg.data == $past(addrData)))
		else $error("data field not returned");

	// Pin driver against code, subslot and style
	a_unassigned_off: assert property ((st_reg.curCode == CODE_OFF) |=> !st_reg.pinOe)
		else $error("unassigned slot drove the pin");
	a_sub_inactive: assert property ((st_reg.curCode inside {[4'h2:4'h7]} && !bitAct) |=>
		!st_reg.pinOe)
		else $error("subchannel drove outside its subslot");
	a_od_low_only: assert property ((st_reg.outMode[STYLE_BIT] ##1 st_reg.pinOe) |-> !st_reg.pinOut)
		else $error("open drain drove high");
	a_pp_follows: assert property ((!st_reg.outMode[STYLE_BIT] && bitAct) |=>
		st_reg.pinOe && (st_reg.pinOut == $past(bitVal)))
		else $error("push-pull level wrong");

	// Open drain: a zero bit pulls low, a one bit lets the line float up
	a_od_drives_low: assert property ((st_reg.outMode[STYLE_BIT] && bitAct && !bitVal) |=>
		(st_reg.pinOe && !st_reg.pinOut))
		else $error("open drain did not pull low");
	a_od_one_off: assert property ((st_reg.outMode[STYLE_BIT] && bitAct && bitVal) |=> !st_reg.pinOe)
		else $error("open drain drove a one");

	// Register writes from the bus land at the access edge
	a_data_reg_write: assert property ((apbWrite && (apbReq.paddr == OFS_DATA) && !st_reg.busy) |=>
		(st_reg.data == $past(apbReq.pwdata[7:0])))
		else $error("data register write lost");
	// Command byte is kept whole for the access cycle
	a_cmd_latched: assert property (cmdTaken |=> (st_reg.cmd == $past(apbReq.pwdata[7:0])))
		else $error("command byte not latched");
	// Status is read-only: a bus write never raises busy
	a_stat_no_write: assert property ((apbWrite && (apbReq.paddr == OFS_STAT) && !st_reg.busy) |=>
		!st_reg.busy)
		else $error("status write raised busy");

	// A write to one block leaves the other block alone
	a_up_untouched: assert property ((st_reg.busy && isBoth && !isRead && !st_reg.addr[DIR_UP_BIT])
		|=> (st_reg.codeUp[slotIdx] == $past(st_reg.codeUp[slotIdx])))
		else $error("down write changed up block");
	a_down_untouched: assert property ((st_reg.busy && isBoth && !isRead && st_reg.addr[DIR_UP_BIT])
		|=> (st_reg.codeDn[slotIdx] == $past(st_reg.codeDn[slotIdx])))
		else $error("up write changed down block");

	// Slot start loads the code and pointer that the pin side uses
	a_slot_code_load: assert property (timing.slotStart |=> (st_reg.curCode == $past(nextCode)))
		else $error("slot code not loaded");
	a_slot_ptr_load: assert property (timing.slotStart |=> (slotPtr == $past(nextPtr)))
		else $error("slot pointer not loaded");
	// Bit 7 leads every slot
	a_slot_msb_first: assert property (timing.slotStart |=> (st_reg.bitPos == 3'h7))
		else $error("slot did not start at bit 7");
	// Switched codes flag a meaningful pointer, 1xxx codes the other functions
	a_switched_flag: assert property ((timing.slotStart && (nextCode inside {[CODE_64K:4'h7]})) |=>
		(slotPtrValid && !slotOtherFunc))
		else $error("switched slot not flagged");
	a_other_flag: assert property ((timing.slotStart && nextCode[3]) |=> (slotOtherFunc && !slotPtrValid))
		else $error("non-switching slot not flagged");

	// Main scenarios worth seeing at least once
	c_both_write: cover property (st_reg.busy && isBoth && !isRead);
	c_code_read: cover property (st_reg.busy && isBoth && isRead ##1 !st_reg.busy);
	c_od_drive: cover property (st_reg.outMode[STYLE_BIT] && st_reg.pinOe);
	c_buf_full: cover property (st_reg.cnt == BUF_FULL && inValid);
	c_data_only: cover property (st_reg.busy && isDataOnly && !isRead);
endmodule

//--- tb/ccm_line_model.sv
`timescale 1ns/1ns
// Slot sequencer and pulled-up serial line at the pin side
module ccm_line_model
	import ccm_pkg::*;
(
	// Clock
	input wire logic clk,
	// Pin from the block
	input wire logic cfiOut,
	input wire logic cfiOe,
	// Slot timing to the block
	output ccm_timing_type timing
);
	logic [7:0] oeSeen; // Enable per bit of the last slot
	logic [7:0] lineSeen; // Line level per bit, pull-up when undriven
	initial timing = '0;
	// One slot: start pulse, then a tick every fourth cycle, bit 7 first
	task automatic frame(input logic [6:0] n);
		timing.slotNum <= n;
		timing.slotStart <= 1'b1;
		@(posedge clk);
		timing.slotStart <= 1'b0;
		for (int b = 7; b >= 0; b--)
		begin
			repeat (3) @(posedge clk);
			// Sampled mid-bit, well clear of the pin update edge
			oeSeen[b] = cfiOe;
			lineSeen[b] = cfiOe ? cfiOut : 1'b1;
			timing.bitTick <= (b > 0);
			@(posedge clk);
			timing.bitTick <= 1'b0;
		end
	endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ns
// Self-checking bench for the control memory access block
module testbench;
	import ccm_pkg::*;
	logic clk = 1'b0; // 20 MHz
	logic sysRst = 1'b1;
	ccm_apb_req_type req = '0;
	ccm_apb_rsp_type rsp;
	ccm_timing_type timing;
	logic [7:0] inByte = 8'h00;
	logic inValid = 1'b0;
	logic inReady;
	logic cfiOut;
	logic cfiOe;
	logic [7:0] slotPtr;
	logic slotPtrValid;
	logic slotOtherFunc;
	logic [31:0] rdata; // Last read data
	logic err; // Last error answer
	int failCount = 0;
	int nCompared = 0;
	always #25 clk = ~clk;
	ccm_control_memory u_dut (.clk(clk), .sys_rst(sysRst), .apbReq(req), .apbRsp(rsp), .timing(timing),
		.inByte(inByte), .inValid(inValid), .inReady(inReady), .cfiOut(cfiOut), .cfiOe(cfiOe),
		.slotPtr(slotPtr), .slotPtrValid(slotPtrValid), .slotOtherFunc(slotOtherFunc));
	ccm_line_model u_line (.clk(clk), .cfiOut(cfiOut), .cfiOe(cfiOe), .timing(timing));
	// Verdict and end of run
	task automatic test_done;
		$display("compared %0d, mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// A bound ran out
	task automatic hang;
		failCount++;
		$display("unexpected at %0t: wait bound exhausted", $time);
		test_done();
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		nCompared++;
		if (seen !== exp)
		begin
			failCount++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	// One APB transfer, held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int i;
		req.paddr <= a;
		req.pwrite <= wr;
		req.pwdata <= {24'h000000, d};
		req.psel <= 1'b1;
		@(posedge clk);
		req.penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge clk);
			if (rsp.pready === 1'b1)
				break;
		end
		rdata = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (i == 16)
			hang();
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk(rdata & m, e, "read");
	endtask
	// Command, then poll busy before any result is used
	task automatic cmd(input logic [7:0] c);
		apb(1'b1, OFS_CMD, c);
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b0, OFS_STAT, 8'h00);
			if (rdata[BUSY_BIT] === 1'b0)
				return;
		end
		hang();
	endtask
	task automatic prog(input logic [7:0] a, input logic [3:0] c, input logic [7:0] d);
		apb(1'b1, OFS_DATA, d);
		apb(1'b1, OFS_ADDR, a);
		cmd({4'h7, c});
	endtask
	// Offer one byte; bounded wait for acceptance
	task automatic push(input logic [7:0] b);
		int i;
		inByte <= b;
		inValid <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge clk);
			if (inReady === 1'b1)
				break;
		end
		inValid <= 1'b0;
		if (i == 16)
			hang();
		@(posedge clk);
	endtask
	// Whether a bit position is driven for a code and subslot choice
	function automatic logic act(input logic [3:0] c, input logic [1:0] s, input logic [2:0] p);
		if (c[3])
			return 1'b1;
		if (c[2])
			return p[2:1] == s;
		if (c[1])
			return p[2] == s[1];
		return c[0];
	endfunction
	task automatic slot_check(input logic st, input logic [3:0] c, input logic [1:0] s, input logic [7:0] b);
		logic [7:0] eo;
		logic [7:0] el;
		apb(1'b1, OFS_OUTMODE, {7'h00, st});
		apb(1'b1, OFS_SUBSEL, {6'h00, s});
		prog(8'h05, c, ~b);
		push(b);
		u_line.frame(7'h05);
		for (int p = 0; p < 8; p++)
		begin
			eo[p] = act(c, s, 3'(p)) & (~st | ~b[p]);
			el[p] = act(c, s, 3'(p)) ? b[p] : 1'b1;
		end
		chk(u_line.oeSeen, eo, "enable");
		chk(u_line.lineSeen, el, "line");
		chk(slotPtr, {24'h0, ~b}, "pointer");
		chk({slotPtrValid, slotOtherFunc}, {(c != CODE_OFF) && !c[3], c[3]}, "function flags");
	endtask
	// Reset values, read-only status, unmapped address
	task automatic t_regs;
		rd(OFS_CMD, '1, 32'h0);
		rd(OFS_DATA, '1, 32'h0);
		rd(OFS_ADDR, '1, 32'h0);
		rd(OFS_STAT, '1, 32'h0);
		apb(1'b1, OFS_SUBSEL, 8'h02);
		rd(OFS_SUBSEL, '1, 32'h2);
		apb(1'b1, OFS_STAT, 8'hff);
		rd(OFS_STAT, '1, 32'h0);
		apb(1'b0, 8'h40, 8'h00);
		chk({31'h0, err}, 32'h1, "slverr");
		chk(rdata, 32'h0, "unmapped data");
		$display("registers test done");
	endtask
	// Code and data fields, both directions, data-only opcode
	task automatic t_code;
		prog(8'hfb, CODE_64K, 8'hc6);
		cmd(8'hf0);
		rd(OFS_DATA, 32'h0f, 32'h1);
		cmd(8'hc8);
		rd(OFS_DATA, '1, 32'hc6);
		apb(1'b1, OFS_ADDR, 8'h7b);
		cmd(8'hf0);
		rd(OFS_DATA, 32'h0f, 32'h0);
		apb(1'b1, OFS_DATA, 8'h5a);
		apb(1'b1, OFS_ADDR, 8'hfb);
		cmd(8'h48);
		cmd(8'hf0);
		rd(OFS_DATA, 32'h0f, 32'h1);
		cmd(8'hc8);
		rd(OFS_DATA, '1, 32'h5a);
		$display("code field test done");
	endtask
	// Codes 0 to 11, both driver styles, rotating subslot choice
	task automatic t_pins;
		for (int k = 0; k < 24; k++)
			slot_check(k >= 12, 4'(k % 12), 2'(k), 8'ha5 ^ 8'(k));
		$display("pin test done");
	endtask
	// Fill the buffer while no slot runs, then drain past empty
	task automatic t_buf;
		apb(1'b1, OFS_OUTMODE, 8'h00);
		prog(8'h05, CODE_64K, 8'h00);
		push(8'h11);
		push(8'h22);
		chk({31'h0, inReady}, 32'h0, "ready when full");
		u_line.frame(7'h05);
		chk(u_line.lineSeen, 32'h11, "first byte");
		u_line.frame(7'h05);
		chk(u_line.lineSeen, 32'h22, "second byte");
		u_line.frame(7'h05);
		chk(u_line.lineSeen, {24'h0, IDLE_BYTE}, "idle byte");
		$display("buffer test done");
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_code();
		t_pins();
		t_buf();
		test_done();
	end
	// Hang guard, about 100000 cycles
	initial
	begin
		#5000000;
		hang();
	end
endmodule
